// file: design/flash_security_pkg.sv
/*
  flash_security_pkg: constants and carrier types shared by the flash
  security block. assumes a 25 MHz system clock and a word register port.
*/
package flash_security_pkg;

  // register map (byte addresses on the local port)
  localparam logic [7:0]  SEC_CTRL_OFFSET  = 8'h10;
  localparam logic [7:0]  FLASH_CS_OFFSET  = 8'h20;
  localparam logic [7:0]  FLASH_CMD_OFFSET = 8'h24;
  localparam logic [7:0]  MODE_OFFSET      = 8'h28;

  // field positions
  localparam int          SEC_EN_BIT       = 0;
  localparam int          READY_BIT        = 0;
  localparam int          PROT_LSB         = 16;
  localparam int          NUM_BLOCKS       = 10;

  // reset values
  localparam logic        SEC_EN_RESET     = 1'b1;
  localparam logic [1:0]  MODE_RESET       = 2'h0;

  // unlock key and window
  localparam logic [31:0] UNLOCK_KEY       = 32'hA74A9D23;
  localparam int          UNLOCK_WINDOW    = 16;

  // flash protection commands (written to the command register)
  localparam logic [7:0]  CMD_PROTECT      = 8'hA1;
  localparam logic [7:0]  CMD_ERASE_PROT   = 8'hA2;

  // operating modes
  typedef enum logic [1:0] {
    MODE_SINGLE_CHIP = 2'b00,
    MODE_SINGLE_BOOT = 2'b01,
    MODE_WRITER      = 2'b10,
    MODE_OTHER       = 2'b11
  } op_mode_type;

  // register port read/write request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        full_word;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } reg_req_type;

  // flash command carried to the protection store
  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
    logic [3:0] block;
  } prot_cmd_type;

endpackage

// file: design/flash_security_unlock.sv
/*
  flash_security_unlock: security enable register, unlock sequence and
  protection-bit command path for on-chip flash. assumes software on
  clk_sys drives a one-cycle read/write strobe port; power_on_reset is
  the cold reset, reset the lighter system reset.
*/
// Summary of operation
// - only a cold reset restores the security control register
// - power-on reset forces security enable to one
// - software writes the 32-bit unlock key before changing the bit
// - data write must follow the key within 16 clocks
// - key and data count only as full 32-bit writes
// - protection writes and erases work in chip, boot and writer modes
// - each protect command changes one flash block only
// - erase with all protected and security on clears every bit
// - protection bits change only through flash commands and power-on reset
// - security active only when enable and all protection bits are one
// - active security blocks debug and all flash command writes except erase
`timescale 1ns/1ps
module flash_security_unlock
  import flash_security_pkg::*;
(
  // clock and resets
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        power_on_reset,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        full_word,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic [31:0]      rdata,
  // flash status
  input  wire logic        flash_ready,
  // security outputs
  output logic             security_active,
  output logic             debug_block
);

  reg_req_type           req;
  prot_cmd_type          cmd;
  logic                  rewrite_ok;
  logic                  sec_en_q;
  logic [1:0]            mode_q;
  logic [NUM_BLOCKS-1:0] prot;
  logic                  all_prot;
  logic                  mode_ok;
  logic                  cmd_wr;
  logic [31:0]           rdata_d;

  assign req = '{wr: wr_en, rd: rd_en, full_word: full_word, addr: addr, wdata: wdata};

  unlock_window u_unlock (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .req        (req),
    .rewrite_ok (rewrite_ok)
  );

  // security enable: lighter reset does not touch it
  always_ff @(posedge clk_sys) begin
    if (power_on_reset) begin
      sec_en_q <= SEC_EN_RESET;
    end else if (rewrite_ok) begin
      sec_en_q <= wdata[SEC_EN_BIT];
    end
  end

  // operating mode, a plain register here since no mode pin is modelled
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_q <= MODE_RESET;
    end else if (wr_en && addr == MODE_OFFSET) begin
      mode_q <= wdata[1:0];
    end
  end

  assign all_prot        = &prot;
  assign security_active = sec_en_q && all_prot;
  assign debug_block     = security_active;
  assign mode_ok         = (op_mode_type'(mode_q) != MODE_OTHER);
  assign cmd_wr          = wr_en && addr == FLASH_CMD_OFFSET && full_word && flash_ready;

  // command path; the erase opcode still passes while locked so the
  // bulk erase can strip protection; the key sequence can also clear enable
  always_comb begin
    cmd = '{valid: 1'b0, opcode: wdata[7:0], block: wdata[11:8]};
    if (cmd_wr && mode_ok) begin
      if (!security_active) begin
        cmd.valid = 1'b1;
      end else if (wdata[7:0] == CMD_ERASE_PROT) begin
        cmd.valid = 1'b1;
      end
    end
  end

  protect_store u_store (
    .clk_sys (clk_sys),
    .reset   (power_on_reset),
    .cmd     (cmd),
    .prot_q  (prot)
  );

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_en) begin
      case (addr)
        SEC_CTRL_OFFSET:  rdata_d[SEC_EN_BIT] = sec_en_q;
        FLASH_CS_OFFSET: begin
          rdata_d[PROT_LSB +: NUM_BLOCKS] = prot;
          rdata_d[READY_BIT]              = flash_ready;
        end
        MODE_OFFSET:      rdata_d[1:0] = mode_q;
        default:          rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= rdata_d;
    end
  end

  a_cold_only : assert property (@(posedge clk_sys) disable iff (power_on_reset)
    (reset && !rewrite_ok) |=> sec_en_q == $past(sec_en_q))
    else $error("security enable changed by light reset");

  a_por_sets : assert property (@(posedge clk_sys)
    power_on_reset |=> sec_en_q)
    else $error("power-on reset left security off");

  a_upper_zero : assert property (@(posedge clk_sys) disable iff (reset)
    (rd_en && addr == SEC_CTRL_OFFSET) |=> rdata[31:1] == 31'h0 && rdata[0] == sec_en_q)
    else $error("security control readback wrong");

  a_locked_cmd : assert property (@(posedge clk_sys) disable iff (power_on_reset)
    (security_active && cmd.valid) |-> cmd.opcode == CMD_ERASE_PROT)
    else $error("command accepted while locked");

  a_bulk_erase : assert property (@(posedge clk_sys) disable iff (power_on_reset)
    (security_active && cmd.valid) |=> prot == '0 ##1 !security_active)
    else $error("bulk erase did not clear protection");

  a_active_def : assert property (@(posedge clk_sys)
    security_active == (sec_en_q && (&prot)))
    else $error("security active mismatch");

endmodule

// file: design/protect_store.sv
/*
  protect_store: per-block write/erase protection bits.
  assumes commands arrive already qualified by the control logic.
*/
`timescale 1ns/1ps
module protect_store
  import flash_security_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  // command
  input  wire prot_cmd_type          cmd,
  // state
  output logic [NUM_BLOCKS-1:0]      prot_q
);

  logic [NUM_BLOCKS-1:0] onehot;

  assign onehot = NUM_BLOCKS'(1) << cmd.block;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prot_q <= '0;
    end else if (cmd.valid && cmd.opcode == CMD_PROTECT && cmd.block < 4'(NUM_BLOCKS)) begin
      prot_q <= prot_q | onehot;
    end else if (cmd.valid && cmd.opcode == CMD_ERASE_PROT) begin
      prot_q <= '0;
    end
  end

  a_single_block : assert property (@(posedge clk_sys) disable iff (reset)
    (cmd.valid && cmd.opcode == CMD_PROTECT) |=> $countones(prot_q ^ $past(prot_q)) <= 1)
    else $error("protect touched more than one block");

endmodule

// file: design/unlock_window.sv
/*
  unlock_window: key-then-data sequencer for the security enable bit.
  assumes requests on clk_sys from the local register port.
*/
`timescale 1ns/1ps
module unlock_window
  import flash_security_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // register requests
  input  wire reg_req_type req,
  // result
  output logic             rewrite_ok
);

  logic       armed_q;
  logic [4:0] count_q;
  logic       to_ctrl;
  logic       key_hit;

  assign to_ctrl = req.wr && (req.addr == SEC_CTRL_OFFSET);
  // narrow transfers never count as key or data
  assign key_hit = to_ctrl && req.full_word && (req.wdata == UNLOCK_KEY);
  assign rewrite_ok = armed_q && to_ctrl && req.full_word && !key_hit;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      armed_q <= 1'b0;
      count_q <= 5'h00;
    end else if (key_hit) begin
      armed_q <= 1'b1;
      count_q <= 5'h00;
    end else if (armed_q && (req.wr || count_q == 5'(UNLOCK_WINDOW - 1))) begin
      // any other write or the window running out drops the key
      armed_q <= 1'b0;
      count_q <= 5'h00;
    end else if (armed_q) begin
      count_q <= count_q + 5'h01;
    end
  end

  // the last free cycle must close the window, else a late data write slips in
  a_window_bound : assert property (@(posedge clk_sys) disable iff (reset)
    (armed_q && !key_hit && count_q == 5'(UNLOCK_WINDOW - 1)) |=> !armed_q)
    else $error("unlock window not closed");

  a_key_needed : assert property (@(posedge clk_sys) disable iff (reset)
    rewrite_ok |-> $past(armed_q) || armed_q)
    else $error("rewrite without key");

  a_narrow_ignored : assert property (@(posedge clk_sys) disable iff (reset)
    (req.wr && !req.full_word) |-> !rewrite_ok)
    else $error("narrow write accepted");

  a_drop_on_write : assert property (@(posedge clk_sys) disable iff (reset)
    (armed_q && req.wr && !key_hit) |=> !armed_q)
    else $error("key kept after other write");

endmodule

// file: testbench/tb_top.sv
/*
  tb_top: self-checking bench for flash_security_unlock.
  assumes the package and design files are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  import flash_security_pkg::*;
  logic                  clk_sys, reset, power_on_reset, full_word, wr_en, rd_en;
  logic                  flash_ready, security_active, debug_block, sec_e;
  logic [7:0]            addr;
  logic [31:0]           wdata, rdata;
  logic [1:0]            mode_e;
  logic [NUM_BLOCKS-1:0] prot_e;
  integer                seed = 32'h55F8FA63;
  int                    mismatches = 0;
  int                    cmp_count = 0;
  int                    gaps[3] = '{16, 15, 0};

  flash_security_unlock dut (.clk_sys(clk_sys), .reset(reset),
    .power_on_reset(power_on_reset), .addr(addr), .wdata(wdata),
    .full_word(full_word), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .flash_ready(flash_ready), .security_active(security_active),
    .debug_block(debug_block));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task end_of_test;
    if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  // strobe stays high so a second call can follow with no gap
  task wr(input logic [7:0] a, input logic [31:0] d, input logic fw);
    addr <= a; wdata <= d; full_word <= fw; wr_en <= 1'b1; rd_en <= 1'b0;
    @(posedge clk_sys);
  endtask

  task idle(input int n);
    wr_en <= 1'b0; rd_en <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask

  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [31:0] e, input string what);
    addr <= a; wr_en <= 1'b0; rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 chk(what, e, rdata);
    @(posedge clk_sys);
  endtask

  function logic [31:0] flcs_exp;
    return {6'h00, prot_e, 15'h0000, flash_ready};
  endfunction

  task cmd(input logic [7:0] op, input logic [3:0] b);
    if (flash_ready && mode_e != 2'h3) begin
      if (op == CMD_ERASE_PROT) prot_e = '0;
      else if (!(sec_e && &prot_e)) prot_e[b] = 1'b1;
    end
    wr(FLASH_CMD_OFFSET, {20'h00000, b, op}, 1'b1);
    idle(1);
    rd(FLASH_CS_OFFSET, flcs_exp(), "protect");
  endtask

  // gap counts idle cycles between key and data
  task unlock(input int gap, input logic v, input logic fw);
    wr(SEC_CTRL_OFFSET, UNLOCK_KEY, fw);
    if (gap > 0) idle(gap);
    wr(SEC_CTRL_OFFSET, {31'h0, v}, 1'b1);
    if (fw && gap < UNLOCK_WINDOW) sec_e = v;
    idle(1);
    rd(SEC_CTRL_OFFSET, {31'h0, sec_e}, "enable");
  endtask

  task set_mode(input logic [1:0] m);
    wr(MODE_OFFSET, {30'h0, m}, 1'b1);
    mode_e = m;
  endtask

  initial begin
    repeat (4000) @(posedge clk_sys);
    mismatches++;
    end_of_test();
  end

  initial begin
    {full_word, wr_en, rd_en, addr, wdata} = '0;
    reset = 1'b1; power_on_reset = 1'b1; flash_ready = 1'b1;
    sec_e = 1'b1; prot_e = '0; mode_e = 2'h0;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0; power_on_reset <= 1'b0;
    @(posedge clk_sys);
    rd(SEC_CTRL_OFFSET, 32'h00000001, "enable");
    rd(8'h04, 32'h00000000, "unmapped");
    wr(SEC_CTRL_OFFSET, 32'h00000000, 1'b1);
    idle(1);
    rd(SEC_CTRL_OFFSET, 32'h00000001, "enable");
    unlock(0, 1'b0, 1'b0);
    foreach (gaps[i]) unlock(gaps[i], ~sec_e, 1'b1);
    wr(SEC_CTRL_OFFSET, UNLOCK_KEY, 1'b1);
    set_mode(2'h0);
    wr(SEC_CTRL_OFFSET, 32'h00000000, 1'b1);
    idle(1);
    rd(SEC_CTRL_OFFSET, {31'h0, sec_e}, "enable");
    for (int m = 0; m < 4; m++) begin
      set_mode(m[1:0]);
      repeat (3) cmd(CMD_PROTECT, 4'($unsigned($random(seed)) % NUM_BLOCKS));
      cmd(CMD_ERASE_PROT, 4'h0);
    end
    set_mode(2'h0);
    flash_ready <= 1'b0;
    idle(1);
    cmd(CMD_PROTECT, 4'h2);
    flash_ready <= 1'b1;
    idle(1);
    for (int b = 0; b < NUM_BLOCKS; b++) cmd(CMD_PROTECT, b[3:0]);
    chk("active", 32'h1, {31'h0, security_active});
    chk("debug", 32'h1, {31'h0, debug_block});
    cmd(CMD_ERASE_PROT, 4'h0);
    chk("active", 32'h0, {31'h0, security_active});
    unlock(0, 1'b0, 1'b1);
    for (int b = 0; b < NUM_BLOCKS; b++) cmd(CMD_PROTECT, b[3:0]);
    chk("active", 32'h0, {31'h0, security_active});
    // light reset must leave enable and protection alone
    reset <= 1'b1;
    idle(2);
    reset <= 1'b0;
    idle(1);
    rd(SEC_CTRL_OFFSET, 32'h00000000, "enable");
    rd(FLASH_CS_OFFSET, flcs_exp(), "protect");
    power_on_reset <= 1'b1;
    reset <= 1'b1;
    idle(2);
    power_on_reset <= 1'b0;
    reset <= 1'b0;
    sec_e = 1'b1;
    prot_e = '0;
    idle(1);
    rd(SEC_CTRL_OFFSET, 32'h00000001, "enable");
    rd(FLASH_CS_OFFSET, flcs_exp(), "protect");
    end_of_test();
  end
endmodule
